/* File: hdl/pac_pkg.sv */
// shared constants and types for the parallel converter port
package pac_pkg;
    localparam int PAC_RES_BITS = 10;
    localparam logic [9:0] PAC_CODE_FULL = 10'h3FF;
    localparam logic [9:0] PAC_CODE_ZERO = 10'h000;
    localparam logic [9:0] PAC_LATCH_RST = 10'h000;
    localparam logic [3:0] PAC_ZERO_CNT = 4'h0;
    localparam logic [3:0] PAC_BIT_TOP = 4'h9;
    // internal clock: one approximation step every N reference cycles
    localparam int PAC_INT_DIV = 8;
    localparam logic [3:0] PAC_DIV_LAST = 4'(PAC_INT_DIV - 1);
    // external clock must fall this many times before it takes over
    localparam logic [3:0] PAC_EXT_TAKE = 4'h4;
    localparam int PAC_CLK_NS = 10;
    localparam int PAC_DONE_CLEAR_NS = 20;
    localparam int PAC_DONE_CLEAR_CYC = (PAC_DONE_CLEAR_NS / PAC_CLK_NS) < 1 ? 1 : (PAC_DONE_CLEAR_NS / PAC_CLK_NS);
    typedef enum logic [2:0] {
        PAC_ST_SAMPLE = 3'b001,
        PAC_ST_HOLD = 3'b010,
        PAC_ST_LATCH = 3'b100
    } pac_state_t;
endpackage

/* File: hdl/pac_latch.sv */
// output latch holding the last finished result
`timescale 1ns/100ps
`default_nettype none
module pac_latch import pac_pkg::*; #(
    parameter int W = PAC_RES_BITS
) (
    input wire logic clk_i, // reference clock
    input wire logic rst_n_i, // async reset, low
    input wire logic load_i, // capture strobe
    input wire logic [W-1:0] data_i, // new result
    output logic [W-1:0] data_o // stored result
);
    logic [W-1:0] data_d;
    // load only on the strobe, otherwise keep
    always_comb begin
        data_d = load_i ? data_i : data_o;
    end
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            data_o <= W'(PAC_LATCH_RST);
        end else begin
            data_o <= data_d;
        end
    end
endmodule // pac_latch
`default_nettype wire

/* File: hdl/pac_conv.sv */
// control and read-out of a 10-bit successive-approximation converter
// Contract
// R1 - result bit 0 is the lsb and bit 9 (the tenth) is the msb on the data pins.
// R2 - a conversion starts on the rising write strobe while chip select is low.
// R3 - that edge switches the input to hold until the conversion completes.
// R4 - outside a conversion the input is sampled and tracked.
// R5 - on completion the result goes to the latch, then done is driven low.
// R6 - the latch takes a new result only at the falling edge of done.
// R7 - with chip select and read strobe low the latch drives the data bus.
// R8 - a falling read strobe returns done high within the clear delay; one that falls in the latch cycle leaves done low.
// R9 - the host sees completion by interrupt on done or by polling it.
// R10 - an input at or above the top reference gives all ones.
// R11 - an input at or below the bottom reference gives all zeros.
// R12 - an input between references gives a code proportional to its position.
// R13 - strobes are ignored unless chip select is low.
// R14 - pulses on the external clock input replace the internal clock.
// R15 - the data pins float whenever chip select or read strobe is high.
`timescale 1ns/100ps
`default_nettype none
module pac_conv import pac_pkg::*; #(
    parameter int W = PAC_RES_BITS
) (
    input wire logic REF_CLK_I, // 100 MHz reference clock
    input wire logic RESET_N_I, // async reset, low
    input wire logic CS_N_I, // chip select, low
    input wire logic WR_N_I, // write strobe, low
    input wire logic RD_N_I, // read strobe, low
    input wire logic EXTERNAL_CLOCK_IN_I, // external conversion clock, idle high
    input wire logic [W-1:0] ANALOG_INPUT_I, // input position within the span
    input wire logic [W-1:0] REF_POS_I, // top reference position
    input wire logic [W-1:0] REF_NEG_I, // bottom reference position
    output logic [W-1:0] DATA_O, // data bus out
    output logic [W-1:0] DATA_OE_O, // data bus drive enable, high drives
    output logic DONE_N_O, // end of conversion, low
    output logic HOLD_O // high while input is held
);
    // elaboration checks: the package fixes the code width, and the divider must fit its 4-bit counter
    if (W != PAC_RES_BITS) begin : g_bad_width
        $error("pac_conv serves 10-bit results only");
    end
    if (PAC_INT_DIV < 1 || PAC_INT_DIV > 16) begin : g_bad_div
        $error("pac_conv divider must fit its 4-bit counter");
    end

    pac_state_t st_q, st_d;
    logic wr_q, rd_q, ck_q, done_q;
    logic wr_d, rd_d, ck_d, done_d;
    logic [W-1:0] held_q, held_d, sar_q, sar_d;
    logic [3:0] bit_q, bit_d, div_q, div_d, ext_cnt_q, ext_cnt_d;
    logic [W-1:0] latch_val;
    logic start, rd_fall, step, done_fall, ext_edge, hi_ext;
    logic [W-1:0] trial, span, pos;
    logic [2*W-1:0] prod;

    // strobe edges qualified by chip select
    // only the rising write edge counts; select is looked at on that same edge
    assign start = !wr_q && WR_N_I && !CS_N_I; // [R2] [R13]
    assign rd_fall = rd_q && !RD_N_I && !CS_N_I; // [R8] [R13]
    assign ext_edge = !ck_q && EXTERNAL_CLOCK_IN_I;
    assign hi_ext = ext_cnt_q == PAC_EXT_TAKE;
    // step source: external pulses once seen, else internal divider [R14]
    assign step = hi_ext ? ext_edge : (div_q == PAC_DIV_LAST);
    assign done_fall = done_q && st_q == PAC_ST_LATCH;

    // comparator model: clamp to references, then scale the held level to the span
    // the divide only runs strictly inside the span, so a zero span never reaches it
    always_comb begin
        span = REF_POS_I - REF_NEG_I;
        pos = held_q - REF_NEG_I;
        prod = {{W{1'b0}}, pos} * {{W{1'b0}}, PAC_CODE_FULL};
        if (held_q >= REF_POS_I) begin
            trial = PAC_CODE_FULL; // [R10]
        end else if (held_q <= REF_NEG_I) begin
            trial = PAC_CODE_ZERO; // [R11]
        end else begin
            trial = W'(prod / {{W{1'b0}}, span}); // [R12]
        end
    end

    // next state of converter and handshake
    always_comb begin
        st_d = st_q;
        sar_d = sar_q;
        bit_d = bit_q;
        held_d = held_q;
        done_d = done_q;
        wr_d = WR_N_I;
        rd_d = RD_N_I;
        ck_d = EXTERNAL_CLOCK_IN_I;
        div_d = (div_q == PAC_DIV_LAST) ? PAC_ZERO_CNT : div_q + 4'h1;
        ext_cnt_d = ext_cnt_q;
        // external pulses seen: count low phases; once the count is reached it stays external
        if (!EXTERNAL_CLOCK_IN_I && ck_q && !hi_ext) begin
            ext_cnt_d = ext_cnt_q + 4'h1; // [R14]
        end
        if (rd_fall) begin
            done_d = 1'b1; // [R8]
        end
        case (st_q)
            PAC_ST_SAMPLE: begin
                held_d = ANALOG_INPUT_I; // track while idle [R4]
                if (start) begin
                    st_d = PAC_ST_HOLD; // [R3]
                    sar_d = PAC_CODE_ZERO;
                    bit_d = PAC_BIT_TOP;
                end
            end
            PAC_ST_HOLD: begin
                if (step) begin
                    // one trial bit per step, msb first
                    sar_d[bit_q] = trial[bit_q]; // [R12]
                    if (bit_q == PAC_ZERO_CNT) begin
                        st_d = PAC_ST_LATCH;
                    end else begin
                        bit_d = bit_q - 4'h1;
                    end
                end
            end
            PAC_ST_LATCH: begin
                done_d = 1'b0; // latch loads this cycle if done was high, done falls with it [R5]
                st_d = PAC_ST_SAMPLE; // [R4]
            end
            default: st_d = PAC_ST_SAMPLE;
        endcase
    end

    // converter, strobe and clock-edge registers
    always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            st_q <= PAC_ST_SAMPLE;
            sar_q <= PAC_CODE_ZERO;
            bit_q <= PAC_ZERO_CNT;
            held_q <= PAC_CODE_ZERO;
            done_q <= 1'b1;
            wr_q <= 1'b1;
            rd_q <= 1'b1;
            ck_q <= 1'b1;
            div_q <= PAC_ZERO_CNT;
            ext_cnt_q <= PAC_ZERO_CNT;
        end else begin
            st_q <= st_d;
            sar_q <= sar_d;
            bit_q <= bit_d;
            held_q <= held_d;
            done_q <= done_d;
            wr_q <= wr_d;
            rd_q <= rd_d;
            ck_q <= ck_d;
            div_q <= div_d;
            ext_cnt_q <= ext_cnt_d;
        end
    end

    // result latch loads only with the falling edge of done [R6]
    pac_latch #(.W(W)) u_latch (
        .clk_i(REF_CLK_I),
        .rst_n_i(RESET_N_I),
        .load_i(done_fall),
        .data_i(sar_q),
        .data_o(latch_val)
    );

    // registered pins; bus drives one cycle after read and select go low
    always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            DATA_O <= PAC_CODE_ZERO;
            DATA_OE_O <= PAC_CODE_ZERO;
            DONE_N_O <= 1'b1;
            HOLD_O <= 1'b0;
        end else begin
            DATA_O <= latch_val; // bit 0 lsb, bit 9 msb [R1]
            DATA_OE_O <= (!CS_N_I && !RD_N_I) ? PAC_CODE_FULL : PAC_CODE_ZERO; // [R7] [R15]
            DONE_N_O <= done_d; // [R5] [R8]
            HOLD_O <= st_d == PAC_ST_HOLD; // [R3] [R4]
        end
    end

    AST_START_HOLDS: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I) // [R2]
        start && st_q == PAC_ST_SAMPLE |=> HOLD_O) else $error("write edge did not hold input");
    AST_DONE_CLEAR: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I) // [R8]
        rd_fall && st_q != PAC_ST_LATCH |=> ##[0:1] DONE_N_O) else $error("read did not clear done");
    AST_LATCH_EDGE: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I) // [R6]
        $changed(latch_val) |-> $past(done_fall)) else $error("latch changed without done edge");
    AST_DRIVE: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I) // [R7]
        !CS_N_I && !RD_N_I |=> DATA_OE_O == PAC_CODE_FULL) else $error("bus not driven on read");
    AST_FLOAT: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I) // [R15]
        CS_N_I || RD_N_I |=> DATA_OE_O == PAC_CODE_ZERO) else $error("bus driven while deselected");
    AST_IGNORE: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I) // [R13]
        CS_N_I && st_q == PAC_ST_SAMPLE |=> st_q == PAC_ST_SAMPLE) else $error("strobe taken without select");
    AST_DONE_LOW: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I) // [R5]
        st_q == PAC_ST_LATCH ##1 1'b1 |-> !DONE_N_O && latch_val == $past(sar_q)) else $error("done low without result");
    AST_SAMPLE: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I) // [R4]
        st_q == PAC_ST_SAMPLE && !start |=> !HOLD_O) else $error("hold outside conversion");
    // the held level must not move while the bit trials run
    AST_HOLD_FROZEN: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I) // [R3]
        st_q == PAC_ST_HOLD |=> held_q == $past(held_q)) else $error("held input moved in conversion");
    // done stays low until a read clears it
    AST_DONE_STAYS: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I) // [R5]
        !DONE_N_O && !rd_fall |=> !DONE_N_O) else $error("done rose without read");
    // a held level at or above the top reference finishes as all ones
    AST_FULL_CODE: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I) // [R10]
        st_q == PAC_ST_LATCH && held_q >= REF_POS_I |-> sar_q == PAC_CODE_FULL) else $error("top input not full");
    // a held level at or below the bottom reference finishes as all zeros
    AST_ZERO_CODE: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I) // [R11]
        st_q == PAC_ST_LATCH && held_q <= REF_NEG_I |-> sar_q == PAC_CODE_ZERO) else $error("bottom input not zero");
    // data pins mirror the latch bit for bit, one cycle later
    AST_DATA_PINS: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I) // [R1]
        1'b1 |=> DATA_O == $past(latch_val)) else $error("data pins differ from latch");
    // once the external clock has taken over, no trial without one of its rising edges
    AST_EXT_STEP: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I) // [R14]
        hi_ext && st_q == PAC_ST_HOLD && !ext_edge |=> bit_q == $past(bit_q)) else $error("step without clock");
    // during the bit trials the read strobe resets done in the cycle after its falling edge
    AST_READ_CLEARS: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I) // [R8]
        rd_fall && st_q == PAC_ST_HOLD |=> DONE_N_O) else $error("done not cleared by read");
endmodule // pac_conv
`default_nettype wire

/* File: verification/pac_host_model.sv */
// host bus model that starts conversions and reads results
`timescale 1ns/100ps
`default_nettype none
module pac_host_model (
    input wire logic clk_i, // reference clock
    input wire logic done_n_i, // end of conversion, low
    output logic cs_n_o, // chip select, low
    output logic wr_n_o, // write strobe, low
    output logic rd_n_o // read strobe, low
);
    initial begin
        cs_n_o = 1'b1;
        wr_n_o = 1'b1;
        rd_n_o = 1'b1;
    end
    // write pulse; select stays put one edge past the rise so the rise is seen with it
    task automatic start_conv(input logic sel_n);
        @(posedge clk_i);
        #1 cs_n_o = sel_n;
        wr_n_o = 1'b0;
        repeat (5) @(posedge clk_i);
        #1 wr_n_o = 1'b1;
        @(posedge clk_i);
        #1 cs_n_o = 1'b1;
    endtask
    // polls done under a bound, then a read pulse of 50 ns
    task automatic read_word(output bit ok);
        int n;
        n = 0;
        while (done_n_i !== 1'b0 && n < 300) begin
            @(posedge clk_i);
            n++;
        end
        ok = (n < 300);
        #1 cs_n_o = 1'b0;
        rd_n_o = 1'b0;
        repeat (5) @(posedge clk_i);
        #1 rd_n_o = 1'b1;
        @(posedge clk_i);
        #1 cs_n_o = 1'b1;
    endtask
endmodule // pac_host_model
`default_nettype wire

/* File: verification/parallel_adc_conversion_port_bench.sv */
// self-checking bench for the converter control and read-out port
`timescale 1ns/100ps
`default_nettype none
module parallel_adc_conversion_port_bench;
    import pac_pkg::*;
    logic clk = 1'b0;
    logic rst_n;
    logic [9:0] analog_input, refp, refn, data, oe, oe_prev, exp_v, exp_w;
    logic done_n, hold, cs_n, wr_n, rd_n;
    logic [9:0] exp_q[$];
    int err_count = 0;
    int comparisons = 0;
    bit ok;
    logic ext_clk;
    bit ext_run = 1'b0;
    always #5 clk = ~clk;
    pac_host_model host (.clk_i(clk), .done_n_i(done_n), .cs_n_o(cs_n), .wr_n_o(wr_n), .rd_n_o(rd_n));
    // external clock idles high (internal divider) until the last conversions switch it on
    pac_conv DUT (.REF_CLK_I(clk), .RESET_N_I(rst_n), .CS_N_I(cs_n), .WR_N_I(wr_n), .RD_N_I(rd_n),
        .EXTERNAL_CLOCK_IN_I(ext_clk), .ANALOG_INPUT_I(analog_input), .REF_POS_I(refp), .REF_NEG_I(refn),
        .DATA_O(data), .DATA_OE_O(oe), .DONE_N_O(done_n), .HOLD_O(hold));
    task automatic check(input logic [9:0] seen, input logic [9:0] expv);
        comparisons++;
        if (seen !== expv) begin
            err_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, expv);
        end
    endtask
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // result check on the first cycle the bus is driven; negedge keeps clear of register updates
    always @(negedge clk) begin
        if (oe === 10'h3FF && oe_prev !== 10'h3FF) begin
            exp_w = (exp_q.size() > 0) ? exp_q.pop_front() : 10'bx;
            check(data, exp_w);
        end
        oe_prev <= oe;
    end
    // external conversion clock, 16 reference cycles a period once switched on
    initial begin
        ext_clk = 1'b1;
        wait (ext_run);
        forever begin
            repeat (8) @(posedge clk);
            #1 ext_clk = ~ext_clk;
        end
    end
    initial begin
        #100000;
        err_count++;
        end_sim;
    end
    // corner codes first, then random inputs, all in random spans; input moves during hold to prove it is frozen
    initial begin
        rst_n = 1'b0;
        analog_input = 10'h000;
        refp = 10'h3FF;
        refn = 10'h000;
        void'($urandom(35005));
        repeat (10) @(posedge clk);
        #1 rst_n = 1'b1;
        for (int i = 0; i < 10; i++) begin
            refn = 10'($urandom_range(0, 255));
            refp = 10'($urandom_range(768, 1023));
            case (i)
                0: analog_input = refp;
                1: analog_input = refn;
                2: analog_input = 10'h3FF;
                3: analog_input = 10'h000;
                default: analog_input = 10'($urandom_range(refn, refp));
            endcase
            if (analog_input >= refp) exp_v = PAC_CODE_FULL;
            else if (analog_input <= refn) exp_v = PAC_CODE_ZERO;
            else exp_v = 10'((int'(analog_input - refn) * 1023) / int'(refp - refn));
            exp_q.push_back(exp_v);
            if (i == 7) begin
                ext_run = 1'b1;
                repeat (80) @(posedge clk);
            end
            host.start_conv(1'b0);
            @(posedge clk);
            #1 check({9'h000, hold}, 10'h001);
            analog_input = 10'($urandom);
            if (i >= 7) begin
                // internal pacing would be done by now; external pacing takes about twice as long
                repeat (100) @(posedge clk);
                #1 check({9'h000, done_n}, 10'h001);
            end
            host.read_word(ok);
            check({9'h000, ok}, 10'h001);
            check({9'h000, hold}, 10'h000);
            repeat (2) @(posedge clk);
            #1 check({9'h000, done_n}, 10'h001);
            check(oe, 10'h000);
        end
        host.start_conv(1'b1);
        repeat (3) @(posedge clk);
        #1 check({9'h000, hold}, 10'h000);
        end_sim;
    end
endmodule // parallel_adc_conversion_port_bench
`default_nettype wire
